// ### design/pcdm_top.sv
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/10ps
// Functional notes
// - Magnitude and stuck checks each run only when their own enable bit is 1.
// - Data checks run only out of shutdown with the amplifier path enabled.
// - Tone source selected suppresses all input data checks.
// - Persistence setting gives how long a bad condition must last.
// - Input data fault clears global enable and raises the input fault event.
// - Repeated identical samples above the stuck limit too long flag a stuck fault.
// - Repeated samples within the stuck limit never flag a stuck fault.
// - Samples above the magnitude limit too long flag a magnitude fault.
// - Clock watch enabled checks bit and frame clocks while global enable is 1, clock hold included.
// - Tone source enabled suppresses clock monitoring and its events.
// - Automatic mode shuts down with enable kept at 1, then self recovers.
// - Automatic mode fault and recovery events alternate unless the monitor is disabled during a hold.
// - Manual mode fault clears enable, no recovery, monitoring resumes on re-enable.
// - Host entry to or exit from shutdown raises no clock events.
// - Frame rate equals sample rate, bit rate is ratio times sample rate.
// - Each frame period both clock rates are checked against a 45% window.
// - More than frequency tolerance consecutive bad periods raise a clock fault.
// - Automatic mode recovers after more than frequency tolerance consecutive good periods.
// - Bit clocks per frame are compared with the configured ratio.
// - I2S and LJ also require equal halves, TDM has no duty check.
// - More than ratio tolerance consecutive bad frames raise a clock fault.
// - Automatic mode recovers after more than ratio tolerance consecutive good frames.
module pcdm_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic bclk_pin,
  input wire logic lrclk_pin,
  input wire logic [23:0] sample_in,
  input wire logic sample_valid,
  output logic input_fault_irq,
  output logic clock_fault_irq,
  output logic clock_recover_irq,
  output logic sw_shutdown
);
  logic [31:0] ctrl_r;
  logic [31:0] cfg_r;
  logic [22:0] stuck_level_limit;
  logic [22:0] magnitude_level_limit;
  logic [2:0] sticky_r;
  logic global_en_clr;
  pcdm_pkg::pcdm_cm_state_type cm_state_r;
  pcdm_pkg::pcdm_cm_state_type cm_state_nxt;

  logic global_en;
  logic amp_path_on;
  logic tone_on;
  logic magnitude_check_on;
  logic stuck_check_on;
  logic clock_watch_on;
  logic clock_auto_recover;
  logic [1:0] frame_format;
  logic [3:0] persist_time_sel;
  logic [3:0] freq_fault_tolerance;
  logic [3:0] ratio_fault_tolerance;
  logic [3:0] sample_rate_sel;
  logic [3:0] bits_per_frame_sel;

  assign global_en = ctrl_r[pcdm_pkg::GLOBAL_EN_BIT];
  assign amp_path_on = ctrl_r[pcdm_pkg::AMP_PATH_BIT];
  assign tone_on = ctrl_r[pcdm_pkg::TONE_BIT];
  assign magnitude_check_on = ctrl_r[pcdm_pkg::MAG_ON_BIT];
  assign stuck_check_on = ctrl_r[pcdm_pkg::STUCK_ON_BIT];
  assign clock_watch_on = ctrl_r[pcdm_pkg::CLK_WATCH_BIT];
  assign clock_auto_recover = ctrl_r[pcdm_pkg::AUTO_REC_BIT];
  assign frame_format = ctrl_r[pcdm_pkg::FORMAT_LSB +: 2];
  assign persist_time_sel = cfg_r[pcdm_pkg::PERSIST_LSB +: 4];
  assign freq_fault_tolerance = cfg_r[pcdm_pkg::FREQ_TOL_LSB +: 4];
  assign ratio_fault_tolerance = cfg_r[pcdm_pkg::RATIO_TOL_LSB +: 4];
  assign sample_rate_sel = cfg_r[pcdm_pkg::RATE_LSB +: 4];
  assign bits_per_frame_sel = cfg_r[pcdm_pkg::BPF_LSB +: 4];

  // Shutdown is either the global enable low or a clock monitor hold.
  assign sw_shutdown = !global_en || (cm_state_r == pcdm_pkg::CM_DOWN);

  // Register writes; a hardware fault clearing the enable wins over software.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= pcdm_pkg::CTRL_RESET;
      cfg_r <= pcdm_pkg::CFG_RESET;
      stuck_level_limit <= pcdm_pkg::LIMIT_RESET;
      magnitude_level_limit <= pcdm_pkg::LIMIT_RESET;
    end else begin
      if (reg_wr && reg_addr == pcdm_pkg::CTRL_ADDR) begin
        ctrl_r <= {22'h0, reg_wdata[9:0]};
      end
      if (reg_wr && reg_addr == pcdm_pkg::CFG_ADDR) begin
        cfg_r <= {12'h0, reg_wdata[19:0]};
      end
      if (reg_wr && reg_addr == pcdm_pkg::STUCK_ADDR) begin
        stuck_level_limit <= reg_wdata[22:0];
      end
      if (reg_wr && reg_addr == pcdm_pkg::MAG_ADDR) begin
        magnitude_level_limit <= reg_wdata[22:0];
      end
      if (global_en_clr) begin
        ctrl_r[pcdm_pkg::GLOBAL_EN_BIT] <= 1'b0;
      end
    end
  end

  // Sticky event bits, write one to clear, a new event wins over the clear.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sticky_r <= 3'h0;
    end else begin
      sticky_r <= (sticky_r & ~((reg_wr && reg_addr == pcdm_pkg::STATUS_ADDR) ?
                  reg_wdata[2:0] : 3'h0)) |
                  {clock_recover_irq, clock_fault_irq, input_fault_irq};
    end
  end

  // Read data stands in the cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        pcdm_pkg::CTRL_ADDR: reg_rdata <= ctrl_r;
        pcdm_pkg::CFG_ADDR: reg_rdata <= cfg_r;
        pcdm_pkg::STUCK_ADDR: reg_rdata <= {9'h0, stuck_level_limit};
        pcdm_pkg::MAG_ADDR: reg_rdata <= {9'h0, magnitude_level_limit};
        pcdm_pkg::STATUS_ADDR: reg_rdata <= {22'h0, cm_state_r == pcdm_pkg::CM_DOWN,
                                             sw_shutdown, 5'h0, sticky_r};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // Input data monitor.
  logic dmon_active;
  logic [23:0] prev_sample_r;
  logic [22:0] sample_mag;
  logic [15:0] stuck_run_r;
  logic [15:0] mag_run_r;
  logic [15:0] persist_len;
  logic stuck_fault;
  logic mag_fault;

  assign dmon_active = global_en && !sw_shutdown && amp_path_on && !tone_on;
  assign sample_mag = sample_in[23] ? 23'(-sample_in) : sample_in[22:0];
  assign persist_len = 16'(pcdm_pkg::PERSIST_BASE) << persist_time_sel;
  assign stuck_fault = stuck_check_on && (stuck_run_r > persist_len);
  assign mag_fault = magnitude_check_on && (mag_run_r > persist_len);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_sample_r <= 24'h0;
      stuck_run_r <= 16'h0;
      mag_run_r <= 16'h0;
    end else if (!dmon_active) begin
      stuck_run_r <= 16'h0;
      mag_run_r <= 16'h0;
    end else if (sample_valid) begin
      prev_sample_r <= sample_in;
      if (sample_in == prev_sample_r && sample_mag > stuck_level_limit) begin
        stuck_run_r <= (stuck_run_r == 16'hffff) ? stuck_run_r : stuck_run_r + 16'h1;
      end else begin
        stuck_run_r <= 16'h0;
      end
      if (sample_mag > magnitude_level_limit) begin
        mag_run_r <= (mag_run_r == 16'hffff) ? mag_run_r : mag_run_r + 16'h1;
      end else begin
        mag_run_r <= 16'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      input_fault_irq <= 1'b0;
    end else begin
      input_fault_irq <= dmon_active && (stuck_fault || mag_fault) && !input_fault_irq;
    end
  end

  // Link clock synchronisers and edge detection.
  logic [2:0] bclk_sync_r;
  logic [2:0] lrclk_sync_r;
  logic bclk_rise;
  logic lr_rise;
  logic lr_fall;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bclk_sync_r <= 3'h0;
      lrclk_sync_r <= 3'h0;
    end else begin
      bclk_sync_r <= {bclk_sync_r[1:0], bclk_pin};
      lrclk_sync_r <= {lrclk_sync_r[1:0], lrclk_pin};
    end
  end

  assign bclk_rise = bclk_sync_r[1] && !bclk_sync_r[2];
  assign lr_rise = lrclk_sync_r[1] && !lrclk_sync_r[2];
  assign lr_fall = !lrclk_sync_r[1] && lrclk_sync_r[2];

  // Expected frame period and bit clocks per frame.
  logic [15:0] frame_cyc;
  logic [15:0] bpf;
  logic [15:0] lr_min;
  logic [15:0] lr_max;
  logic [15:0] bclk_min;
  logic [15:0] bclk_max;

  always_comb begin
    unique case (sample_rate_sel)
      4'h0: frame_cyc = 16'(pcdm_pkg::FRAME_CYC_32K);
      4'h1: frame_cyc = 16'(pcdm_pkg::FRAME_CYC_44K1);
      4'h3: frame_cyc = 16'(pcdm_pkg::FRAME_CYC_88K2);
      4'h4: frame_cyc = 16'(pcdm_pkg::FRAME_CYC_96K);
      default: frame_cyc = 16'(pcdm_pkg::FRAME_CYC_48K);
    endcase
    unique case (bits_per_frame_sel)
      4'h0: bpf = 16'd32;
      4'h1: bpf = 16'd48;
      4'h2: bpf = 16'd64;
      4'h3: bpf = 16'd96;
      4'h4: bpf = 16'd128;
      4'h5: bpf = 16'd192;
      4'h6: bpf = 16'd256;
      4'h7: bpf = 16'd384;
      default: bpf = 16'd512;
    endcase
  end

  assign lr_min = frame_cyc - 16'((32'(frame_cyc) * pcdm_pkg::FREQ_TOL_PCT) / 100);
  assign lr_max = frame_cyc + 16'((32'(frame_cyc) * pcdm_pkg::FREQ_TOL_PCT) / 100);
  assign bclk_min = bpf - 16'((32'(bpf) * pcdm_pkg::FREQ_TOL_PCT) / 100);
  assign bclk_max = bpf + 16'((32'(bpf) * pcdm_pkg::FREQ_TOL_PCT) / 100);

  // Clock measurement runs in the running and held states only.
  logic cm_meas;
  logic lr_seen_r;
  logic [15:0] lr_per_r;
  logic lr_per_bad_r;
  logic [15:0] win_cnt_r;
  logic [15:0] win_bclk_r;
  logic win_end;
  logic freq_err;
  logic [15:0] bits_cnt_r;
  logic [15:0] half_cnt_r;
  logic [15:0] half_a_r;
  logic frame_done;
  logic frame_err;

  assign cm_meas = (cm_state_r != pcdm_pkg::CM_OFF);
  assign win_end = cm_meas && (win_cnt_r == frame_cyc - 16'h1);
  assign freq_err = lr_per_bad_r || (lr_per_r > lr_max) ||
                    (win_bclk_r < bclk_min) || (win_bclk_r > bclk_max);
  assign frame_done = cm_meas && lr_rise && lr_seen_r;
  assign frame_err = (bits_cnt_r != bpf) ||
                     (frame_format != pcdm_pkg::FMT_TDM && half_a_r != half_cnt_r);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lr_seen_r <= 1'b0;
      lr_per_r <= 16'h0;
      lr_per_bad_r <= 1'b0;
      win_cnt_r <= 16'h0;
      win_bclk_r <= 16'h0;
      bits_cnt_r <= 16'h0;
      half_cnt_r <= 16'h0;
      half_a_r <= 16'h0;
    end else if (!cm_meas) begin
      lr_seen_r <= 1'b0;
      lr_per_r <= 16'h0;
      lr_per_bad_r <= 1'b0;
      win_cnt_r <= 16'h0;
      win_bclk_r <= 16'h0;
      bits_cnt_r <= 16'h0;
      half_cnt_r <= 16'h0;
      half_a_r <= 16'h0;
    end else begin
      win_cnt_r <= win_end ? 16'h0 : win_cnt_r + 16'h1;
      if (win_end) begin
        win_bclk_r <= {15'h0, bclk_rise};
      end else if (bclk_rise && win_bclk_r != 16'hffff) begin
        win_bclk_r <= win_bclk_r + 16'h1;
      end
      if (lr_rise) begin
        lr_seen_r <= 1'b1;
        lr_per_r <= 16'h1;
        lr_per_bad_r <= lr_seen_r && (lr_per_r < lr_min || lr_per_r > lr_max);
      end else if (lr_per_r != 16'hffff) begin
        lr_per_r <= lr_per_r + 16'h1;
      end
      if (lr_rise) begin
        bits_cnt_r <= {15'h0, bclk_rise};
        half_cnt_r <= {15'h0, bclk_rise};
      end else if (lr_fall) begin
        half_a_r <= half_cnt_r;
        half_cnt_r <= {15'h0, bclk_rise};
        bits_cnt_r <= bits_cnt_r + {15'h0, bclk_rise};
      end else if (bclk_rise) begin
        bits_cnt_r <= bits_cnt_r + 16'h1;
        half_cnt_r <= half_cnt_r + 16'h1;
      end
    end
  end

  // Consecutive bad and good counters, frequency and ratio kept apart.
  logic [4:0] freq_bad_r;
  logic [4:0] freq_good_r;
  logic [4:0] ratio_bad_r;
  logic [4:0] ratio_good_r;
  logic cm_fault;
  logic cm_recovered;
  logic cm_change;

  assign cm_fault = (freq_bad_r > {1'b0, freq_fault_tolerance}) ||
                    (ratio_bad_r > {1'b0, ratio_fault_tolerance});
  assign cm_recovered = (freq_good_r > {1'b0, freq_fault_tolerance}) &&
                        (ratio_good_r > {1'b0, ratio_fault_tolerance});
  assign cm_change = (cm_state_nxt != cm_state_r);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      freq_bad_r <= 5'h0;
      freq_good_r <= 5'h0;
      ratio_bad_r <= 5'h0;
      ratio_good_r <= 5'h0;
    end else if (!cm_meas || cm_change) begin
      freq_bad_r <= 5'h0;
      freq_good_r <= 5'h0;
      ratio_bad_r <= 5'h0;
      ratio_good_r <= 5'h0;
    end else begin
      if (win_end && freq_err) begin
        freq_bad_r <= (freq_bad_r == 5'h1f) ? freq_bad_r : freq_bad_r + 5'h1;
        freq_good_r <= 5'h0;
      end else if (win_end) begin
        freq_good_r <= (freq_good_r == 5'h1f) ? freq_good_r : freq_good_r + 5'h1;
        freq_bad_r <= 5'h0;
      end
      if (frame_done && frame_err) begin
        ratio_bad_r <= (ratio_bad_r == 5'h1f) ? ratio_bad_r : ratio_bad_r + 5'h1;
        ratio_good_r <= 5'h0;
      end else if (frame_done) begin
        ratio_good_r <= (ratio_good_r == 5'h1f) ? ratio_good_r : ratio_good_r + 5'h1;
        ratio_bad_r <= 5'h0;
      end
    end
  end

  // Clock monitor state machine.
  logic cm_enable;

  assign cm_enable = clock_watch_on && !tone_on && global_en;

  always_comb begin
    cm_state_nxt = cm_state_r;
    unique case (cm_state_r)
      pcdm_pkg::CM_OFF: begin
        if (cm_enable) begin
          cm_state_nxt = pcdm_pkg::CM_RUN;
        end
      end
      pcdm_pkg::CM_RUN: begin
        if (!cm_enable) begin
          cm_state_nxt = pcdm_pkg::CM_OFF;
        end else if (cm_fault) begin
          cm_state_nxt = clock_auto_recover ? pcdm_pkg::CM_DOWN : pcdm_pkg::CM_OFF;
        end
      end
      pcdm_pkg::CM_DOWN: begin
        if (!cm_enable) begin
          cm_state_nxt = pcdm_pkg::CM_OFF;
        end else if (cm_recovered) begin
          cm_state_nxt = pcdm_pkg::CM_RUN;
        end
      end
      default: cm_state_nxt = pcdm_pkg::CM_OFF;
    endcase
  end

  assign global_en_clr = input_fault_irq ||
                         (clock_fault_irq && !clock_auto_recover);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cm_state_r <= pcdm_pkg::CM_OFF;
      clock_fault_irq <= 1'b0;
      clock_recover_irq <= 1'b0;
    end else begin
      cm_state_r <= cm_state_nxt;
      clock_fault_irq <= (cm_state_r == pcdm_pkg::CM_RUN) && cm_enable && cm_fault;
      clock_recover_irq <= (cm_state_r == pcdm_pkg::CM_DOWN) && cm_enable &&
                           cm_recovered;
    end
  end
endmodule : pcdm_top

// ### design/pcdm_pkg.sv
package pcdm_pkg;
  // Register byte addresses.
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] CFG_ADDR = 8'h04;
  localparam logic [7:0] STUCK_ADDR = 8'h08;
  localparam logic [7:0] MAG_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  // Control register fields.
  localparam int GLOBAL_EN_BIT = 0;
  localparam int AMP_PATH_BIT = 1;
  localparam int TONE_BIT = 2;
  localparam int MAG_ON_BIT = 3;
  localparam int STUCK_ON_BIT = 4;
  localparam int CLK_WATCH_BIT = 5;
  localparam int AUTO_REC_BIT = 6;
  localparam int FORMAT_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Configuration register fields, four bits each.
  localparam int PERSIST_LSB = 0;
  localparam int FREQ_TOL_LSB = 4;
  localparam int RATIO_TOL_LSB = 8;
  localparam int RATE_LSB = 12;
  localparam int BPF_LSB = 16;
  localparam logic [31:0] CFG_RESET = 32'h0004_2000;
  localparam logic [22:0] LIMIT_RESET = 23'h7f_ffff;
  // Status register fields.
  localparam int ST_INPUT_FAULT = 0;
  localparam int ST_CLK_FAULT = 1;
  localparam int ST_CLK_RECOVER = 2;
  localparam int ST_SHUTDOWN = 8;
  localparam int ST_CLK_DOWN = 9;
  // Frame formats.
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_TDM = 2'h2;
  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_NS_32K = 31250;
  localparam int FRAME_NS_44K1 = 22676;
  localparam int FRAME_NS_48K = 20833;
  localparam int FRAME_NS_88K2 = 11338;
  localparam int FRAME_NS_96K = 10417;
  localparam int FRAME_CYC_32K = FRAME_NS_32K / CLK_PERIOD_NS;
  localparam int FRAME_CYC_44K1 = FRAME_NS_44K1 / CLK_PERIOD_NS;
  localparam int FRAME_CYC_48K = FRAME_NS_48K / CLK_PERIOD_NS;
  localparam int FRAME_CYC_88K2 = FRAME_NS_88K2 / CLK_PERIOD_NS;
  localparam int FRAME_CYC_96K = FRAME_NS_96K / CLK_PERIOD_NS;
  localparam int FREQ_TOL_PCT = 45;
  localparam int PERSIST_BASE = 8;
  typedef enum logic [1:0] {CM_OFF, CM_RUN, CM_DOWN} pcdm_cm_state_type;
endpackage : pcdm_pkg

// ### tb/pcdm_properties.sv
`timescale 1ns/10ps
module pcdm_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic bclk_pin,
  input wire logic lrclk_pin,
  input wire logic [23:0] sample_in,
  input wire logic sample_valid,
  input wire logic input_fault_irq,
  input wire logic clock_fault_irq,
  input wire logic clock_recover_irq,
  input wire logic sw_shutdown
);
  logic [31:0] c0_r, c1_r, c2_r;
  logic [31:0] on_all, on_any;
  logic seen_r;
  assign on_all = c0_r & c1_r & c2_r;
  assign on_any = c0_r | c1_r | c2_r;
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Control writes are shadowed three deep so event latency never trips a gate check.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c0_r <= 32'h0;
      c1_r <= 32'h0;
      c2_r <= 32'h0;
    end
    else begin
      if (reg_wr && reg_addr == pcdm_pkg::CTRL_ADDR) begin
        c0_r <= reg_wdata;
      end
      c1_r <= c0_r;
      c2_r <= c1_r;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seen_r <= 1'b0;
    end
    else if (clock_fault_irq || clock_recover_irq) begin
      seen_r <= clock_fault_irq;
    end
  end
  property p_in_shut;
    input_fault_irq |-> !sw_shutdown ##1 sw_shutdown;
  endproperty
  a_in_shut: assert property (p_in_shut) else $error("input fault kept running");
  property p_clk_shut;
    $rose(clock_fault_irq) |=> sw_shutdown [*3];
  endproperty
  a_clk_shut: assert property (p_clk_shut) else $error("clock fault kept running");
  property p_rec_order;
    clock_recover_irq |-> seen_r;
  endproperty
  a_rec_order: assert property (p_rec_order) else $error("recovery without fault");
  property p_rec_run;
    clock_recover_irq |-> ##[0:1] !sw_shutdown;
  endproperty
  a_rec_run: assert property (p_rec_run) else $error("recovery left shutdown on");
  property p_tone_quiet;
    on_all[pcdm_pkg::TONE_BIT] |-> !(input_fault_irq || clock_fault_irq || clock_recover_irq);
  endproperty
  a_tone_quiet: assert property (p_tone_quiet) else $error("event with tone on");
  property p_checks_off;
    !on_any[pcdm_pkg::MAG_ON_BIT] && !on_any[pcdm_pkg::STUCK_ON_BIT] |-> !input_fault_irq;
  endproperty
  a_checks_off: assert property (p_checks_off) else $error("input fault, checks off");
  property p_amp_off;
    !on_any[pcdm_pkg::AMP_PATH_BIT] |-> !input_fault_irq;
  endproperty
  a_amp_off: assert property (p_amp_off) else $error("input fault, amp off");
  property p_watch_off;
    !on_any[pcdm_pkg::CLK_WATCH_BIT] |-> !clock_fault_irq && !clock_recover_irq;
  endproperty
  a_watch_off: assert property (p_watch_off) else $error("clock event, watch off");
  property p_manual;
    !on_any[pcdm_pkg::AUTO_REC_BIT] |-> !clock_recover_irq;
  endproperty
  a_manual: assert property (p_manual) else $error("recovery in manual mode");
  c_in: cover property (input_fault_irq);
  c_auto: cover property (clock_fault_irq && on_all[pcdm_pkg::AUTO_REC_BIT]);
  c_rec: cover property (clock_recover_irq);
endmodule : pcdm_properties
bind pcdm_top pcdm_properties u_props (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_pin(bclk_pin),
  .lrclk_pin(lrclk_pin), .sample_in(sample_in), .sample_valid(sample_valid),
  .input_fault_irq(input_fault_irq), .clock_fault_irq(clock_fault_irq),
  .clock_recover_irq(clock_recover_irq), .sw_shutdown(sw_shutdown)
);

// ### tb/pcdm_host.sv
`timescale 1ns/10ps
module pcdm_host (
  input wire logic run,
  input wire logic [9:0] bits,
  input wire logic [3:0] skew,
  output logic bclk,
  output logic lrclk
);
  int i;
  int lo;
  initial begin
    bclk = 1'b0;
    lrclk = 1'b0;
    #3.3;
    forever begin
      if (!run) begin
        // Both clocks stand still low between frames while stopped.
        bclk = 1'b0;
        lrclk = 1'b0;
        #160;
      end
      else begin
        // Low half then high half; a skew moves bit clocks into the high half.
        lo = int'(bits) / 2 - int'(skew);
        for (i = 0; i < int'(bits); i++) begin
          bclk = 1'b0;
          lrclk = (i >= lo) ? 1'b1 : 1'b0;
          #80;
          bclk = 1'b1;
          #80;
        end
      end
    end
  end
endmodule : pcdm_host

// ### tb/pcdm_top_tb.sv
`timescale 1ns/10ps
module pcdm_top_tb;
  localparam logic [31:0] EN = 32'h1 << pcdm_pkg::GLOBAL_EN_BIT;
  localparam logic [31:0] AMP = 32'h1 << pcdm_pkg::AMP_PATH_BIT;
  localparam logic [31:0] TONE = 32'h1 << pcdm_pkg::TONE_BIT;
  localparam logic [31:0] MAG = 32'h1 << pcdm_pkg::MAG_ON_BIT;
  localparam logic [31:0] STK = 32'h1 << pcdm_pkg::STUCK_ON_BIT;
  localparam logic [31:0] WCH = 32'h1 << pcdm_pkg::CLK_WATCH_BIT;
  localparam logic [31:0] AUT = 32'h1 << pcdm_pkg::AUTO_REC_BIT;
  localparam logic [31:0] TDM = 32'(pcdm_pkg::FMT_TDM) << pcdm_pkg::FORMAT_LSB;
  localparam logic [31:0] GATE [3] = '{EN | AMP | MAG | TONE, EN | MAG, AMP | MAG};
  localparam int FR = pcdm_pkg::FRAME_CYC_48K;
  logic ref_clk, rst, reg_wr, reg_rd, sample_valid, bclk_pin, lrclk_pin, host_run;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [23:0] sample_in;
  logic input_fault_irq, clock_fault_irq, clock_recover_irq, sw_shutdown;
  logic [9:0] host_bits;
  logic [3:0] host_skew;
  logic [31:0] rd_q[$];
  logic [2:0] irq_q[$];
  logic rd_d = 1'b0;
  logic [31:0] seed = 32'h0001_5b7e;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  pcdm_top dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_pin(bclk_pin),
    .lrclk_pin(lrclk_pin), .sample_in(sample_in), .sample_valid(sample_valid),
    .input_fault_irq(input_fault_irq), .clock_fault_irq(clock_fault_irq),
    .clock_recover_irq(clock_recover_irq), .sw_shutdown(sw_shutdown)
  );
  pcdm_host host (
    .run(host_run), .bits(host_bits), .skew(host_skew), .bclk(bclk_pin), .lrclk(lrclk_pin)
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [23:0] big();
    logic [23:0] m;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    m = {1'b0, seed[22:0] | 23'h000200};
    return seed[23] ? -m : m;
  endfunction : big
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("unexpected reg_rdata: expected %h seen %h", e, s);
    end
  endtask : chk_rd
  task automatic chk_ev(input logic [2:0] e, input logic [2:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("unexpected irq event: expected %b seen %b", e, s);
    end
  endtask : chk_ev
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Idle cycles carry random address and data that the block must ignore.
    reg_wdata <= {8'h00, big()};
    reg_addr <= seed[7:0];
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= seed[15:8];
  endtask : rd
  task automatic smp(input logic [23:0] v);
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    sample_in <= v;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    sample_in <= big();
  endtask : smp
  task automatic settle(input int lim);
    int k;
    k = 0;
    while (irq_q.size() > 0 && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    if (irq_q.size() > 0) begin
      chk_ev(irq_q.pop_front(), 3'h0);
      irq_q.delete();
    end
    repeat (4) @(posedge ref_clk);
  endtask : settle
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end
    else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // Each read result and each event is taken against the oldest note.
  always @(posedge ref_clk) begin
    if (rd_d) begin
      chk_rd(rd_q.size() > 0 ? rd_q.pop_front() : 32'hx, reg_rdata);
    end
    if (input_fault_irq || clock_fault_irq || clock_recover_irq) begin
      chk_ev(irq_q.size() > 0 ? irq_q.pop_front() : 3'hx,
             {input_fault_irq, clock_fault_irq, clock_recover_irq});
    end
    rd_d <= reg_rd;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 99000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sample_in = 24'h0;
    sample_valid = 1'b0;
    host_run = 1'b0;
    host_bits = 10'h080;
    host_skew = 4'h0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    host_run <= 1'b1;
    rd(pcdm_pkg::CTRL_ADDR, pcdm_pkg::CTRL_RESET);
    rd(pcdm_pkg::CFG_ADDR, pcdm_pkg::CFG_RESET);
    rd(pcdm_pkg::STUCK_ADDR, {9'h0, pcdm_pkg::LIMIT_RESET});
    rd(pcdm_pkg::MAG_ADDR, {9'h0, pcdm_pkg::LIMIT_RESET});
    rd(pcdm_pkg::STATUS_ADDR, 32'h100);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0);
    wr(pcdm_pkg::MAG_ADDR, 32'h100);
    wr(pcdm_pkg::STUCK_ADDR, 32'h100);
    // Magnitude runs at two persistence settings; an at-limit sample breaks a run.
    for (int p = 0; p < 2; p++) begin
      wr(pcdm_pkg::CFG_ADDR, pcdm_pkg::CFG_RESET | 32'(p));
      wr(pcdm_pkg::CTRL_ADDR, EN | AMP | MAG);
      n = pcdm_pkg::PERSIST_BASE << p;
      repeat (n) smp(big());
      smp(24'h000100);
      repeat (n) smp(big());
      irq_q.push_back(3'h4);
      smp(big());
      settle(20);
      rd(pcdm_pkg::CTRL_ADDR, AMP | MAG);
      rd(pcdm_pkg::STATUS_ADDR, 32'h101);
      wr(pcdm_pkg::STATUS_ADDR, 32'h1);
    end
    wr(pcdm_pkg::CFG_ADDR, pcdm_pkg::CFG_RESET);
    wr(pcdm_pkg::CTRL_ADDR, EN | AMP | STK);
    repeat (20) smp(24'h0);
    repeat (20) smp(24'hffff00);
    repeat (20) smp(big());
    repeat (9) smp(24'hfffe00);
    irq_q.push_back(3'h4);
    smp(24'hfffe00);
    settle(20);
    rd(pcdm_pkg::STATUS_ADDR, 32'h101);
    wr(pcdm_pkg::STATUS_ADDR, 32'h1);
    foreach (GATE[i]) begin
      wr(pcdm_pkg::CTRL_ADDR, GATE[i]);
      repeat (12) smp(big());
    end
    rd(pcdm_pkg::STATUS_ADDR, 32'h100);
    wr(pcdm_pkg::CTRL_ADDR, EN | WCH);
    repeat (2 * FR) @(posedge ref_clk);
    wr(pcdm_pkg::CTRL_ADDR, WCH);
    repeat (300) @(posedge ref_clk);
    wr(pcdm_pkg::CTRL_ADDR, EN | WCH);
    repeat (2 * FR) @(posedge ref_clk);
    host_skew <= 4'h1;
    irq_q.push_back(3'h2);
    settle(4 * FR);
    rd(pcdm_pkg::CTRL_ADDR, WCH);
    repeat (2 * FR) @(posedge ref_clk);
    irq_q.push_back(3'h2);
    wr(pcdm_pkg::CTRL_ADDR, EN | WCH);
    settle(4 * FR);
    wr(pcdm_pkg::CTRL_ADDR, EN | WCH | TDM);
    repeat (3 * FR) @(posedge ref_clk);
    host_bits <= 10'h070 + 10'(seed[2:0]);
    irq_q.push_back(3'h2);
    settle(4 * FR);
    host_bits <= 10'h080;
    host_skew <= 4'h0;
    repeat (FR) @(posedge ref_clk);
    wr(pcdm_pkg::CFG_ADDR, 32'h0004_4010);
    irq_q.push_back(3'h2);
    wr(pcdm_pkg::CTRL_ADDR, EN | WCH);
    settle(4 * FR);
    wr(pcdm_pkg::CFG_ADDR, pcdm_pkg::CFG_RESET);
    wr(pcdm_pkg::STATUS_ADDR, 32'h7);
    wr(pcdm_pkg::CTRL_ADDR, EN | WCH | AUT);
    repeat (2 * FR) @(posedge ref_clk);
    host_run <= 1'b0;
    irq_q.push_back(3'h2);
    settle(4 * FR);
    rd(pcdm_pkg::CTRL_ADDR, EN | WCH | AUT);
    rd(pcdm_pkg::STATUS_ADDR, 32'h302);
    host_run <= 1'b1;
    irq_q.push_back(3'h1);
    settle(6 * FR);
    rd(pcdm_pkg::STATUS_ADDR, 32'h006);
    wr(pcdm_pkg::STATUS_ADDR, 32'h7);
    wr(pcdm_pkg::CTRL_ADDR, EN | WCH | AUT | TONE);
    host_run <= 1'b0;
    repeat (3 * FR) @(posedge ref_clk);
    rd(pcdm_pkg::STATUS_ADDR, 32'h000);
    repeat (4) @(posedge ref_clk);
    wrap_up();
  end
endmodule : pcdm_top_tb
